// file: sim/recloser_panel_command_logic_test.sv
// self-checking testbench of the recloser panel command logic
`timescale 1ns/1ps
`default_nettype none
`include "rpc_defines.vh"
module recloser_panel_command_logic_test;
   // ********
   // signals
   // ********
   logic        ref_clk, rst_n, clk_en, avs_read, avs_write, front_port_sel, lw_toggle;
   logic        disc_lw, disc_gnd, disc_ar, lw_def_exp, first_time_current_curve_exp;
   logic        close_malf, inrush_hold_protection_en, inrush_hold_protection_blk;
   logic        fast_trip_dis, slow, avs_waitrequest, seq_reset_r, inrush_start_r;
   logic        lw_active, one_shot_lockout, inrush_hold_allow, fast_trip_dis_eff;
   logic        gnd_block, ar_inhibit, rmt_inhibit, led_lw, led_gate;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [2:0]  handle_open, phase_closed, oc_trip, auto_reclose_req, opt_selected;
   logic [2:0]  trip_cmd_r, close_cmd_r, lockout_r, opt_pulse_r;
   logic [8:0]  fkey, led_fkey;
   logic [4:0]  pb;
   logic [10:0] seen;
   wire         trip_pb = pb[0], close_pb = pb[1], edit_key = pb[2];
   wire         disc_trip = pb[3], disc_close = pb[4];
   int          miscompares, num_checks, seed, ctrl_m, r;
   // short counts keep the run brief
   rpc_panel_cmd #(.EDIT_CYC(32'd50), .PSAVE_CYC(40'd100)) DUT (.*);
   rpc_mech_model u_mech (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // pulses seen between checks, sampled where settled
   always @(negedge ref_clk)
      seen = seen | {inrush_start_r, seq_reset_r, opt_pulse_r, close_cmd_r, trip_cmd_r};
   // ********
   // tasks
   // ********
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is low at a rising edge
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge ref_clk);
      // waitrequest and read data both taken at the rising edge
      while (avs_waitrequest !== 1'b0 && n < 50)
      begin
         @(posedge ref_clk);
         n++;
      end
      q = avs_readdata;
      chk(32'(n < 50), 32'h1);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask
   task press(input int i);
      pb[i] <= 1'b1;
      tick(4);
      pb[i] <= 1'b0;
      tick(4);
   endtask
   task key(input int k);
      fkey[k] <= 1'b1;
      tick(4);
      fkey[k] <= 1'b0;
      tick(4);
   endtask
   task change(input int k);
      press(2);
      key(k);
   endtask
   // live-work request from panel, serial or discrete
   task lw_src(input int s, input logic v);
      case (s)
         0: lw_toggle <= v;
         1: bus(1'b1, `RPC_REG_CTRL, ctrl_m | v);
         default: disc_lw <= v;
      endcase
      tick(4);
   endtask
   task complete_run;
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ********
   // scenarios
   // ********
   initial
   begin
      seed = 56;
      ctrl_m = 8;
      {rst_n, avs_read, avs_write, front_port_sel, lw_toggle, disc_lw, disc_gnd} = '0;
      {disc_ar, lw_def_exp, first_time_current_curve_exp, close_malf, fast_trip_dis} = '0;
      {inrush_hold_protection_en, inrush_hold_protection_blk, slow, oc_trip} = '0;
      {avs_address, avs_writedata, handle_open, auto_reclose_req} = '0;
      {opt_selected, fkey, pb, seen} = '0;
      clk_en = 1'b1;
      tick(3);
      rst_n <= 1'b1;
      front_port_sel <= 1'b1;
      tick(1);
      chk({lockout_r, led_fkey}, 12'hfc0);
      bus(1'b0, `RPC_REG_CTRL, 0);
      chk(q, `RPC_CTRL_RST);
      bus(1'b1, 4'h9, 32'hffffffff);
      bus(1'b0, 4'h9, 0);
      chk(q, 0);
      {inrush_hold_protection_en, inrush_hold_protection_blk} <= 2'($random(seed));
      press(1);
      chk({seen[9], seen[5:3], lockout_r}, 7'h78);
      chk(seen[10], inrush_hold_protection_en & ~inrush_hold_protection_blk);
      {inrush_hold_protection_en, inrush_hold_protection_blk} <= 2'h2;
      seen = '0;
      press(1);
      chk(seen[10], 1'b0);
      // automatic reclose passes, then is held off by the serial inhibit
      for (int a = 0; a < 2; a++)
      begin
         bus(1'b1, `RPC_REG_CTRL, ctrl_m | (a << 2));
         seen = '0;
         auto_reclose_req <= 3'h7;
         tick(1);
         auto_reclose_req <= 3'h0;
         tick(2);
         chk(seen[5:3], a ? 3'h0 : 3'h7);
      end
      bus(1'b1, `RPC_REG_CTRL, ctrl_m);
      seen = '0;
      press(0);
      chk({seen[2:0], lockout_r, phase_closed}, 9'h1f8);
      close_malf <= 1'b1;
      seen = '0;
      press(1);
      chk(seen[5:3], 3'h0);
      close_malf <= 1'b0;
      slow <= 1'b1;
      press(1);
      for (int s = 0; s < 3; s++)
      begin
         seen = '0;
         lw_src(s, 1'b1);
         chk({lw_active, led_lw, seen[2:0]}, 5'h18);
         press(1);
         chk(seen[5:3], 3'h0);
         if (s != 1)
            bus(1'b1, `RPC_REG_CTRL, ctrl_m);
         chk(lw_active, 1'b1);
         lw_src(s, 1'b0);
         chk(lw_active, 1'b0);
      end
      lw_toggle <= 1'b1;
      fast_trip_dis <= 1'b1;
      r = $random(seed);
      tick(4);
      seen = '0;
      {lw_def_exp, first_time_current_curve_exp} <= r[0] ? 2'h2 : 2'h1;
      tick(1);
      {lw_def_exp, first_time_current_curve_exp} <= 2'h0;
      tick(4);
      chk({seen[2:0], lockout_r}, 6'h3f);
      lw_toggle <= 1'b0;
      fast_trip_dis <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         change(k);
         chk({rmt_inhibit, ar_inhibit, gnd_block, led_fkey[2:0]}, {2{3'(1 << k)}});
         change(k);
         chk({rmt_inhibit, ar_inhibit, gnd_block}, 3'h0);
      end
      change(0);
      key(1);
      press(2);
      tick(60);
      key(1);
      chk({ar_inhibit, gnd_block}, 2'h1);
      change(0);
      change(2);
      front_port_sel <= 1'b0;
      bus(1'b1, `RPC_REG_CTRL, ctrl_m | 2);
      disc_gnd <= 1'b1;
      seen = '0;
      press(3);
      bus(1'b1, `RPC_REG_CMD, 32'h1);
      chk({gnd_block, seen[2:0]}, 4'h0);
      front_port_sel <= 1'b1;
      bus(1'b1, `RPC_REG_CTRL, ctrl_m | 6);
      chk({gnd_block, ar_inhibit}, 2'h3);
      disc_gnd <= 1'b0;
      bus(1'b1, `RPC_REG_CTRL, ctrl_m);
      press(0);
      chk(seen[2:0], 3'h7);
      lw_src(0, 1'b1);
      chk(lw_active, 1'b1);
      lw_toggle <= 1'b0;
      change(2);
      opt_selected <= 3'($random(seed));
      for (int i = 0; i < 3; i++)
      begin
         seen = '0;
         change(3 + i);
         chk({seen[8:6], led_fkey[5:3]}, {3'(1 << i), opt_selected});
      end
      for (int m = 0; m < 3; m++)
      begin
         ctrl_m = 8 | (m << 4);
         bus(1'b1, `RPC_REG_CTRL, ctrl_m);
         change(6);
         chk(led_fkey[8:6], m == 2 ? 3'h6 : 3'h7);
      end
      bus(1'b0, `RPC_REG_KEYS, 0);
      chk(q, {3'h6, opt_selected, 3'h0});
      seen = '0;
      press(1);
      chk(seen[5:3], 3'h6);
      seen = '0;
      press(0);
      chk(seen[2:0], 3'h6);
      seen = '0;
      bus(1'b1, `RPC_REG_CMD, 32'h2);
      chk(seen[5:3], 3'h6);
      change(6);
      press(1);
      lw_src(0, 1'b1);
      seen = '0;
      oc_trip <= 3'h1;
      tick(1);
      oc_trip <= 3'h0;
      tick(4);
      press(1);
      chk({seen[5:0], lockout_r[0]}, 7'h03);
      lw_toggle <= 1'b0;
      handle_open <= 3'h7;
      tick(6);
      seen = '0;
      press(1);
      chk({lockout_r, phase_closed, seen[5:3]}, 9'h1c0);
      handle_open <= 3'h0;
      lw_src(0, 1'b1);
      tick(120);
      chk({led_gate, led_lw}, 2'h1);
      press(2);
      chk(led_gate, 1'b1);
      tick(60);
      bus(1'b1, `RPC_REG_CTRL, 0);
      tick(120);
      chk(led_gate, 1'b1);
      complete_run;
   end
   // watchdog against a hung handshake
   initial
   begin
      tick(20000);
      miscompares++;
      complete_run;
   end
endmodule // recloser_panel_command_logic_test
bind rpc_panel_cmd rpc_monitor #(.PSAVE_CYC(PSAVE_CYC)) u_mon (.*);
`default_nettype wire

// file: sim/rpc_mech_model.sv
// behavioural model of the three recloser phase mechanisms
`timescale 1ns/1ps
`default_nettype none
module rpc_mech_model (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // commands and handles
   input wire logic [2:0]  trip_cmd_r,
   input wire logic [2:0]  close_cmd_r,
   input wire logic [2:0]  handle_open,
   input wire logic        slow,
   // contact state
   output var logic [2:0]  phase_closed
);
   // ********
   // mechanism
   // ********
   logic [2:0] c1_r, c2_r, c3_r;
   wire logic [2:0] cl_now = slow ? c3_r : c1_r;
   // closing takes two or four cycles after the close command; opening takes one
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
      begin
         {c1_r, c2_r, c3_r} <= 9'h0;
         phase_closed <= 3'h0;
      end
      else
      begin
         c1_r <= close_cmd_r;
         c2_r <= c1_r;
         c3_r <= c2_r;
         // a handle in close never closes a phase by itself
         phase_closed <= (phase_closed | cl_now) & ~trip_cmd_r & ~handle_open;
      end
endmodule // rpc_mech_model
`default_nettype wire

// file: sim/rpc_monitor.sv
// port checker of the recloser panel command logic
`timescale 1ns/1ps
`default_nettype none
module rpc_monitor #(
   parameter [39:0] PSAVE_CYC = 40'd100
) (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // panel and protection inputs
   input wire logic       edit_key,
   input wire logic       trip_pb,
   input wire logic       close_pb,
   input wire logic [8:0] fkey,
   input wire logic [2:0] handle_open,
   input wire logic       close_malf,
   // design outputs
   input wire logic [2:0] close_cmd_r,
   input wire logic [2:0] opt_pulse_r,
   input wire logic       lw_active,
   input wire logic       one_shot_lockout,
   input wire logic       inrush_hold_allow,
   input wire logic       fast_trip_dis_eff,
   input wire logic       led_lw,
   input wire logic       led_gate
);
   // ********
   // helpers
   // ********
   // idle count from raw pins; it lags the design, hence the slack
   logic [39:0] idle_r;
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         idle_r <= 40'h0;
      else if (edit_key | trip_pb | close_pb | (|fkey))
         idle_r <= 40'h0;
      else
         idle_r <= idle_r + 40'h1;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ********
   // assertions
   // ********
   sequence s_edit_rise;
      $rose(edit_key);
   endsequence
   sequence s_handles_open;
      (handle_open == 3'h7) [*4];
   endsequence
   property p_lw_no_close;
      $past(lw_active) |-> close_cmd_r == 3'h0;
   endproperty
   a_lw_no_close: assert property (p_lw_no_close) else $error("close under block");
   property p_lw_led;
      led_lw == lw_active;
   endproperty
   a_lw_led: assert property (p_lw_led) else $error("block led wrong");
   property p_lw_override;
      lw_active |-> one_shot_lockout && !inrush_hold_allow && !fast_trip_dis_eff;
   endproperty
   a_lw_override: assert property (p_lw_override) else $error("block not dominant");
   property p_malf;
      close_malf |=> close_cmd_r == 3'h0;
   endproperty
   a_malf: assert property (p_malf) else $error("close during malfunction");
   property p_handle;
      s_handles_open |-> close_cmd_r == 3'h0;
   endproperty
   a_handle: assert property (p_handle) else $error("close with handle open");
   property p_idle;
      $fell(led_gate) |-> idle_r + 40'd8 >= PSAVE_CYC;
   endproperty
   a_idle: assert property (p_idle) else $error("leds off too soon");
   property p_wake;
      s_edit_rise |-> ##[1:6] led_gate;
   endproperty
   a_wake: assert property (p_wake) else $error("leds not relit");
   property p_opt_pulse;
      opt_pulse_r != 3'h0 |=> opt_pulse_r == 3'h0;
   endproperty
   a_opt_pulse: assert property (p_opt_pulse) else $error("option pulse too long");
endmodule // rpc_monitor
`default_nettype wire

// file: verilog/rpc_defines.vh
// constants of the recloser panel command logic
`ifndef RPC_DEFINES_VH
`define RPC_DEFINES_VH
// ****************************************************
// clock and timing
// ****************************************************
`define RPC_CLK_HZ        100000000
`define RPC_EDIT_S        10
`define RPC_PSAVE_MIN     10
// ****************************************************
// register word offsets (byte address = 4 * index)
// ****************************************************
`define RPC_REG_CTRL      4'h0
`define RPC_REG_CMD       4'h1
`define RPC_REG_STATUS    4'h2
`define RPC_REG_KEYS      4'h3
// ****************************************************
// control register fields
// ****************************************************
`define RPC_CTRL_LW       0
`define RPC_CTRL_GND      1
`define RPC_CTRL_AR       2
`define RPC_CTRL_PSAVE    3
`define RPC_CTRL_MODE_LO  4
`define RPC_CTRL_MODE_HI  5
`define RPC_CTRL_RST      6'h08
// command register fields (write pulses)
`define RPC_CMD_TRIP      0
`define RPC_CMD_CLOSE     1
// ****************************************************
// operating modes
// ****************************************************
`define RPC_MODE_GANGED   2'h0
`define RPC_MODE_PT3L     2'h1
`define RPC_MODE_PTPL     2'h2
// ****************************************************
// function key positions
// ****************************************************
`define RPC_KEY_GND       0
`define RPC_KEY_AR        1
`define RPC_KEY_RMT       2
`define RPC_KEY_OPT_LO    3
`define RPC_KEY_OPT_HI    5
`define RPC_KEY_PH_LO     6
`define RPC_KEY_PH_HI     8
// ****************************************************
// synchronised pin vector layout
// ****************************************************
`define RPC_PIN_W         24
`endif

// file: verilog/rpc_panel_cmd.v
// operator panel command logic of a triple single pole-mount recloser control
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_defines.vh"
// What this block does
// - live-work block alone never commands a trip
// - live-work refuses closes; single trip to lockout
// - live-work overrides inrush hold, reclose inhibit, fast-disable
// - live-work active while any of three sources
// - each source withdraws only its own request
// - live-work indicator lit while block active
// - power save darkens function key LEDs after ten idle minutes
// - per-phase lockout: overcurrent opens faulted phases only
// - trip pushbutton opens recloser and locks out
// - trip path independent of main processor health
// - close pushbutton resets sequence and closes recloser
// - no close while close-malfunction alarm set
// - close from lockout starts inrush hold protection
// - nine key LEDs show actual function state
// - edit key then one change within ten seconds
// - earth-sensing inhibit blocks all ground sensing
// - reclose inhibit suppresses automatic reclose, keeps curve
// - remote inhibit ignores rear serial and discrete commands other than live-work
// - remote inhibit changed only from panel edit sequence
// - panel trip and close, and live-work from any source, unaffected by remote inhibit
// - option keys give pulses; LEDs show configured option
// - per-phase mode: manual commands act on selected phases
// - handle open trips, locks out, blocks close
// - ganged and three-phase lockout select all phases
module rpc_panel_cmd #(
   parameter [31:0] EDIT_CYC  = `RPC_EDIT_S * `RPC_CLK_HZ,
   parameter [39:0] PSAVE_CYC = `RPC_PSAVE_MIN * 40'd60 * `RPC_CLK_HZ
) (
   // clock, reset, enable
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        clk_en,
   // avalon-mm slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire        front_port_sel,
   // panel pins
   input  wire        lw_toggle,
   input  wire        trip_pb,
   input  wire        close_pb,
   input  wire        edit_key,
   input  wire [8:0]  fkey,
   // recloser phase mechanisms
   input  wire [2:0]  handle_open,
   input  wire [2:0]  phase_closed,
   // discrete supervisory inputs
   input  wire        disc_lw,
   input  wire        disc_gnd,
   input  wire        disc_ar,
   input  wire        disc_trip,
   input  wire        disc_close,
   // protection logic, same clock
   input  wire [2:0]  oc_trip,
   input  wire        lw_def_exp,
   input  wire        first_time_current_curve_exp,
   input  wire [2:0]  auto_reclose_req,
   input  wire        close_malf,
   input  wire        inrush_hold_protection_en,
   input  wire        inrush_hold_protection_blk,
   input  wire        fast_trip_dis,
   input  wire [2:0]  opt_selected,
   // phase commands
   output reg  [2:0]  trip_cmd_r,
   output reg  [2:0]  close_cmd_r,
   output reg  [2:0]  lockout_r,
   output reg         seq_reset_r,
   output reg         inrush_start_r,
   // protection steering
   output wire        lw_active,
   output wire        one_shot_lockout,
   output wire        inrush_hold_allow,
   output wire        fast_trip_dis_eff,
   output wire        gnd_block,
   output wire        ar_inhibit,
   output wire        rmt_inhibit,
   output reg  [2:0]  opt_pulse_r,
   // indicators
   output wire        led_lw,
   output wire [8:0]  led_fkey,
   output wire        led_gate
);
   // ****************************************************
   // pin synchronisers
   // ****************************************************
   wire [`RPC_PIN_W-1:0] pin_raw;
   reg  [`RPC_PIN_W-1:0] pin_s1_r;
   reg  [`RPC_PIN_W-1:0] pin_s2_r;
   reg  [`RPC_PIN_W-1:0] pin_s3_r;
   assign pin_raw = {lw_toggle, trip_pb, close_pb, edit_key, fkey, handle_open,
                     phase_closed, disc_lw, disc_gnd, disc_ar, disc_trip, disc_close};

   // two stages, third only for edge detection
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_r <= {`RPC_PIN_W{1'b0}};
         pin_s2_r <= {`RPC_PIN_W{1'b0}};
         pin_s3_r <= {`RPC_PIN_W{1'b0}};
      end
      else if (clk_en)
      begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   wire [`RPC_PIN_W-1:0] pin_rise = pin_s2_r & ~pin_s3_r;
   wire       s_lw_tog  = pin_s2_r[23];
   wire       r_trip    = pin_rise[22];
   wire       r_close   = pin_rise[21];
   wire       r_edit    = pin_rise[20];
   wire [8:0] r_fkey    = pin_rise[19:11];
   wire [2:0] s_handle  = pin_s2_r[10:8];
   wire [2:0] s_closed  = pin_s2_r[7:5];
   wire       s_dlw     = pin_s2_r[4];
   wire       s_dgnd    = pin_s2_r[3];
   wire       s_dar     = pin_s2_r[2];
   wire       r_dtrip   = pin_rise[1];
   wire       r_dclose  = pin_rise[0];
   wire       any_key   = |pin_rise[22:11];

   // ****************************************************
   // register bus
   // ****************************************************
   reg  [5:0] ctrl_r;
   reg        ack_r;
   wire       bus_req = avs_read | avs_write;
   wire       wr_ok   = avs_write & ~ack_r & clk_en;
   // answer on the second edge: one wait cycle, then data
   assign avs_waitrequest = bus_req & ~ack_r;
   wire [1:0] mode     = ctrl_r[`RPC_CTRL_MODE_HI:`RPC_CTRL_MODE_LO];
   wire       psave_en = ctrl_r[`RPC_CTRL_PSAVE];
   wire       rmt_ok   = ~rmt_inhibit | front_port_sel;
   wire       wr_ctrl  = wr_ok & (avs_address == `RPC_REG_CTRL);
   wire       wr_cmd   = wr_ok & (avs_address == `RPC_REG_CMD);
   wire       c_trip   = wr_cmd & avs_writedata[`RPC_CMD_TRIP] & rmt_ok;
   wire       c_close  = wr_cmd & avs_writedata[`RPC_CMD_CLOSE] & rmt_ok;

   // control register; live-work bit always accepted
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_r <= `RPC_CTRL_RST;
      else if (clk_en && wr_ctrl)
      begin
         ctrl_r[`RPC_CTRL_LW] <= avs_writedata[`RPC_CTRL_LW];
         if (rmt_ok)
         begin
            ctrl_r[`RPC_CTRL_GND] <= avs_writedata[`RPC_CTRL_GND];
            ctrl_r[`RPC_CTRL_AR]  <= avs_writedata[`RPC_CTRL_AR];
         end
         // settings belong to the configuration port only
         if (front_port_sel)
         begin
            ctrl_r[`RPC_CTRL_PSAVE] <= avs_writedata[`RPC_CTRL_PSAVE];
            ctrl_r[5:4] <= avs_writedata[5:4];
         end
      end
   end

   // ****************************************************
   // live-work close block
   // ****************************************************
   reg lw_pnl_r;
   reg lw_dsc_r;
   // each source holds its own request flop
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lw_pnl_r <= 1'b0;
         lw_dsc_r <= 1'b0;
      end
      else if (clk_en)
      begin
         lw_pnl_r <= s_lw_tog;
         lw_dsc_r <= s_dlw;
      end
   end
   assign lw_active = lw_pnl_r | lw_dsc_r | ctrl_r[`RPC_CTRL_LW];
   assign led_lw    = lw_active;
   assign one_shot_lockout  = lw_active;
   assign inrush_hold_allow = inrush_hold_protection_en & ~lw_active;
   assign fast_trip_dis_eff = fast_trip_dis & ~lw_active;

   // ****************************************************
   // edit window and function keys
   // ****************************************************
   reg [31:0] edit_cnt_r;
   reg        edit_open_r;
   reg        gnd_pnl_r;
   reg        ar_pnl_r;
   reg        rmt_r;
   reg [2:0]  phsel_r;
   wire       key_hit = edit_open_r & (|r_fkey);
   wire [2:0] ph_keys = r_fkey[`RPC_KEY_PH_HI:`RPC_KEY_PH_LO];
   // lowest numbered key wins if two hit together
   wire [8:0] key_one = r_fkey & (~r_fkey + 9'h001);

   // a window opens on edit and closes on one change or timeout
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         edit_cnt_r  <= 32'h0;
         edit_open_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (r_edit)
         begin
            edit_open_r <= 1'b1;
            edit_cnt_r  <= 32'h0;
         end
         else if (key_hit || (edit_cnt_r >= EDIT_CYC - 32'h1))
            edit_open_r <= 1'b0;
         else if (edit_open_r)
            edit_cnt_r <= edit_cnt_r + 32'h1;
      end
   end

   // panel-side function states; remote inhibit only here
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gnd_pnl_r   <= 1'b0;
         ar_pnl_r    <= 1'b0;
         rmt_r       <= 1'b0;
         phsel_r     <= 3'h7;
         opt_pulse_r <= 3'h0;
      end
      else if (clk_en)
      begin
         opt_pulse_r <= 3'h0;
         if (key_hit && !r_edit)
         begin
            if (key_one[`RPC_KEY_GND])
               gnd_pnl_r <= ~gnd_pnl_r;
            if (key_one[`RPC_KEY_AR])
               ar_pnl_r <= ~ar_pnl_r;
            if (key_one[`RPC_KEY_RMT])
               rmt_r <= ~rmt_r;
            opt_pulse_r <= key_one[`RPC_KEY_OPT_HI:`RPC_KEY_OPT_LO];
            if (mode == `RPC_MODE_PTPL)
               phsel_r <= phsel_r ^ key_one[`RPC_KEY_PH_HI:`RPC_KEY_PH_LO];
         end
         if (mode != `RPC_MODE_PTPL)
            phsel_r <= 3'h7;
      end
   end

   assign gnd_block   = gnd_pnl_r | ctrl_r[`RPC_CTRL_GND] | (s_dgnd & ~rmt_r);
   assign ar_inhibit  = ar_pnl_r | ctrl_r[`RPC_CTRL_AR] | (s_dar & ~rmt_r);
   assign rmt_inhibit = rmt_r;

   // ****************************************************
   // power save
   // ****************************************************
   reg [39:0] idle_cnt_r;
   reg        leds_on_r;
   // any key press relights and restarts the idle count
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idle_cnt_r <= 40'h0;
         leds_on_r  <= 1'b1;
      end
      else if (clk_en)
      begin
         if (any_key)
         begin
            idle_cnt_r <= 40'h0;
            leds_on_r  <= 1'b1;
         end
         else if (idle_cnt_r >= PSAVE_CYC)
            leds_on_r <= 1'b0;
         else
            idle_cnt_r <= idle_cnt_r + 40'h1;
      end
   end
   assign led_gate = leds_on_r | ~psave_en;
   // lamps follow actual state, whoever set it
   assign led_fkey = {9{led_gate}} & {phsel_r, opt_selected, rmt_r, ar_inhibit,
                                      gnd_block};

   // ****************************************************
   // trip and close sequencing
   // ****************************************************
   wire [2:0] man_mask = (mode == `RPC_MODE_PTPL) ? phsel_r : 3'h7;
   wire       disc_ok  = ~rmt_r;
   wire       man_trip = r_trip | c_trip | (r_dtrip & disc_ok);
   wire       man_cls  = r_close | c_close | (r_dclose & disc_ok);
   wire       lw_prot  = lw_active & (lw_def_exp | first_time_current_curve_exp);
   // handle on one phase takes all three unless per-phase lockout
   wire [2:0] hdl_mask = (mode == `RPC_MODE_PTPL) ? s_handle : {3{|s_handle}};
   wire [2:0] oc_mask  = (mode == `RPC_MODE_PTPL) ? oc_trip : {3{|oc_trip}};
   reg  [2:0] trip_nxt;
   reg  [2:0] lock_nxt;
   reg  [2:0] close_nxt;
   reg        inrush_nxt;

   // trip has priority; live-work alone issues no trip
   always @*
   begin
      trip_nxt = hdl_mask;
      if (man_trip)
         trip_nxt = trip_nxt | man_mask;
      if (lw_prot)
         trip_nxt = trip_nxt | 3'h7;
      trip_nxt = trip_nxt | oc_mask;
      lock_nxt = lockout_r | hdl_mask | (man_trip ? man_mask : 3'h0);
      if (lw_active)
         lock_nxt = lock_nxt | trip_nxt;
      close_nxt  = 3'h0;
      inrush_nxt = 1'b0;
      if (man_cls && !man_trip && !lw_active && !close_malf)
      begin
         close_nxt  = man_mask & ~hdl_mask & ~trip_nxt;
         // only a close from lockout starts the inrush hold
         inrush_nxt = |(close_nxt & lockout_r & ~s_closed) & inrush_hold_allow
                      & ~inrush_hold_protection_blk;
         lock_nxt   = lock_nxt & ~close_nxt;
      end
      else if (!lw_active && !ar_inhibit && !close_malf)
         close_nxt = auto_reclose_req & ~lockout_r & ~hdl_mask & ~trip_nxt;
   end

   // outputs are one-cycle pulses except trip, held while a handle is open; lockout is a level
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trip_cmd_r     <= 3'h0;
         close_cmd_r    <= 3'h0;
         lockout_r      <= 3'h7;
         seq_reset_r    <= 1'b0;
         inrush_start_r <= 1'b0;
      end
      else if (clk_en)
      begin
         trip_cmd_r     <= trip_nxt;
         close_cmd_r    <= close_nxt;
         lockout_r      <= lock_nxt;
         seq_reset_r    <= |close_nxt & man_cls;
         inrush_start_r <= inrush_nxt;
      end
   end

   // ****************************************************
   // register read path
   // ****************************************************
   reg [31:0] rd_nxt;
   always @*
   begin
      case (avs_address)
         `RPC_REG_CTRL:   rd_nxt = {26'h0, ctrl_r};
         `RPC_REG_STATUS: rd_nxt = {14'h0, leds_on_r, edit_open_r, phsel_r, s_closed,
                                   lockout_r, rmt_r, ar_inhibit, gnd_block,
                                   ctrl_r[`RPC_CTRL_LW], lw_dsc_r, lw_pnl_r, lw_active};
         `RPC_REG_KEYS:   rd_nxt = {23'h0, led_fkey};
         default:         rd_nxt = 32'h0;
      endcase
   end

   // ack pulses once per request; data loaded with it
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_r        <= 1'b0;
         avs_readdata <= 32'h0;
      end
      else if (clk_en)
      begin
         ack_r <= bus_req & ~ack_r;
         if (avs_read && !ack_r)
            avs_readdata <= rd_nxt;
      end
   end

endmodule // rpc_panel_cmd
`default_nettype wire
